// ===== bench/serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// serial peer on the receive pin
// ------------------------------
module serial_peer #(
    parameter int BIT_NS = 128
)
(
    output var logic rxd_o,
    output var logic sck_o
);
    // line idles at mark; clocked mode unused, so its clock stands high
    initial
    begin
        rxd_o = 1'b1;
        sck_o = 1'b1;
    end
    // one frame: start, eight data bits lsb first, chosen stop level
    task automatic send(input logic [7:0] d, input logic stop);
        rxd_o = 1'b0;
        #BIT_NS;
        for (int i = 0; i < 8; i++)
        begin
            rxd_o = d[i];
            #BIT_NS;
        end
        rxd_o = stop;
        #BIT_NS;
        rxd_o = 1'b1;
    endtask : send
endmodule : serial_peer
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------
// channel testbench
// ----------------
module testbench;
    import serial_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic rxd, sck, txd_o, txd_oe_o;
    logic rx_error_irq_o, rx_full_irq_o, tx_empty_irq_o, tx_end_irq_o;
    logic [2:0] irq_code_o;
    int num_errors = 0;
    int n_tests = 0;
    // reset values: {addr, expected read data}
    logic [10:0] rows [5] = '{11'h184, 11'h000, 11'h407, 11'h500, 11'h300};
    always #4 clock_i = ~clock_i;
    serial_peer peer (.rxd_o(rxd), .sck_o(sck));
    serial_channel #(.BAUD_DIV(1)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .rxd_i(rxd), .sck_i(sck), .txd_o(txd_o),
        .txd_oe_o(txd_oe_o), .rx_error_irq_o(rx_error_irq_o),
        .rx_full_irq_o(rx_full_irq_o), .tx_empty_irq_o(tx_empty_irq_o),
        .tx_end_irq_o(tx_end_irq_o), .irq_code_o(irq_code_o));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    // one-cycle read strobe, data looked at in the following cycle
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask : rd
    task automatic close_out;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // watchdog well beyond the expected run
    initial
    begin
        #100000;
        num_errors++;
        close_out();
    end
    initial
    begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(rows[i][10:8], rows[i][7:0]);
        // tx interrupts alone, receive side disabled
        wr(OFF_CTRL, 8'h84);
        tick(2);
        chk(tx_empty_irq_o, 1);
        chk(tx_end_irq_o, 1);
        chk(rx_full_irq_o | rx_error_irq_o, 0);
        chk(irq_code_o, IRQ_TXE);
        wr(OFF_CTRL, 8'h50);
        tick(2);
        chk({tx_empty_irq_o, tx_end_irq_o}, 0);
        // clean byte, then read it back
        peer.send(8'ha5, 1'b1);
        tick(8);
        chk(rx_full_irq_o, 1);
        rd(OFF_STAT, 8'hc4);
        rd(OFF_RXH, 8'ha5);
        tick(2);
        chk(rx_full_irq_o, 0);
        // second byte left unread, third overruns
        peer.send(8'h3c, 1'b1);
        peer.send(8'h5a, 1'b1);
        tick(8);
        chk(rx_error_irq_o, 1);
        chk(irq_code_o, IRQ_ERR);
        rd(OFF_STAT, 8'he4);
        rd(OFF_RXH, 8'h3c);
        // clear flags, then a frame with a low stop bit
        wr(OFF_STAT, 8'h84);
        peer.send(8'h00, 1'b0);
        tick(8);
        rd(OFF_STAT, 8'h94);
        // level bit drives the pin while transmit is off
        wr(OFF_PORT, 8'h02);
        tick(3);
        chk({txd_oe_o, txd_o}, 8'h02);
        // one transmitted frame: load sets empty, end follows the stop bit
        wr(OFF_CTRL, 8'h20);
        wr(OFF_TXH, 8'h55);
        rd(OFF_STAT, 8'h90);
        tick(170);
        rd(OFF_STAT, 8'h94);
        wr(OFF_CTRL, 8'h00);
        tick(2);
        chk({txd_oe_o, txd_o}, 8'h02);
        close_out();
    end
endmodule : testbench
`default_nettype wire

// ===== hdl/serial_channel.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module serial_channel
    import serial_pkg::*;
#(
    parameter int BAUD_DIV = 4
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic rxd_i,
    input wire logic sck_i,
    output logic txd_o,
    output logic txd_oe_o,
    output logic rx_error_irq_o,
    output logic rx_full_irq_o,
    output logic tx_empty_irq_o,
    output logic tx_end_irq_o,
    output logic [2:0] irq_code_o
);
    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (BAUD_DIV < 1 || BAUD_DIV > 65535)
    begin : g_bad_div
        $error("BAUD_DIV out of range");
    end

    logic [7:0] ctrl_q;
    logic tx_empty_q, rx_full_q, ovr_q, fer_q, per_q, tx_end_q;
    logic [7:0] txh_q, rxh_q, rdata_q;
    logic dir_q, lvl_q, txd_q;
    logic [1:0] s1_q, s2_q, s3_q, f_q, p_q;
    logic [15:0] div_q, rdiv_q;
    tx_state_type tx_st_q;
    rx_state_type rx_st_q;
    logic [10:0] tx_fr_q;
    logic [3:0] tx_ph_q, tx_bit_q, rx_ph_q, rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_pb_q, brk_q;
    logic [1:0] pend_q;
    logic rx_err_irq_q, rx_full_irq_q, tx_empty_irq_q, tx_end_irq_q;
    logic [2:0] irq_code_q;

    // ----------------------------------------
    // decode and control bits
    // ----------------------------------------
    logic te, re, sync, par_en, err_any;
    logic wr_stat, wr_txh, rd_rxh;
    assign te = ctrl_q[CB_TE];
    assign re = ctrl_q[CB_RE];
    assign sync = ctrl_q[CB_SYNC];
    assign par_en = ctrl_q[CB_PAR];
    assign err_any = ovr_q | fer_q | per_q;
    assign wr_stat = wr_i && addr_i == OFF_STAT;
    assign wr_txh = wr_i && addr_i == OFF_TXH;
    assign rd_rxh = rd_i && addr_i == OFF_RXH;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic rxd_f, rxd_p, sck_f, sck_p, sck_rise, sck_fall;
    assign rxd_f = f_q[0];
    assign rxd_p = p_q[0];
    assign sck_f = f_q[1];
    assign sck_p = p_q[1];
    assign sck_rise = sck_f & ~sck_p;
    assign sck_fall = ~sck_f & sck_p;

    // three stages, a change is taken when the last two agree
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
            s3_q <= 2'h3;
            f_q <= 2'h3;
            p_q <= 2'h3;
        end
        else if (ce_i)
        begin
            s1_q <= {sck_i, rxd_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                f_q <= s3_q;
            end
            p_q <= f_q;
        end
    end

    // ----------------------------------------
    // base tick generators
    // ----------------------------------------
    logic tick, rtick;
    assign tick = div_q == 16'(BAUD_DIV - 1);
    assign rtick = rdiv_q == 16'(BAUD_DIV - 1);

    // ----------------------------------------
    // receiver events
    // ----------------------------------------
    logic rx_start, as_smp, as_fin, sy_fin, sy_abort, rx_fin;
    logic xfer, fer_set, per_set, ovr_set, full_set;
    logic [3:0] rx_last;
    logic [7:0] rx_word;
    assign rx_last = par_en ? 4'ha : 4'h9;
    // falling edge starts a frame; a held break restarts it at once
    assign rx_start = rx_st_q == RX_IDLE && re && !sync
        && !rxd_f && (rxd_p || brk_q);
    assign as_smp = rx_st_q == RX_RUN && rtick && rx_ph_q == SAMPLE_PH;
    assign as_fin = as_smp && rx_bit_q == rx_last;
    assign sy_fin = pend_q == 2'h1 && re;
    assign sy_abort = pend_q != 2'h0 && !re;
    assign rx_fin = as_fin | sy_fin;
    assign rx_word = rx_sh_q;
    // overrun wins over the transfer, errors still flag
    assign ovr_set = rx_fin & rx_full_q;
    assign xfer = rx_fin & ~rx_full_q;
    assign fer_set = as_fin & ~rxd_f;
    assign per_set = as_fin & par_en & (rx_pb_q ^ (^rx_sh_q));
    assign full_set = (xfer & ~fer_set & ~per_set) | sy_abort;

    // ----------------------------------------
    // transmitter events
    // ----------------------------------------
    logic tx_go, tx_done;
    logic [3:0] tx_last;
    logic [10:0] frame;
    assign tx_last = par_en ? 4'ha : 4'h9;
    // start only with data waiting, blocked by errors in sync mode
    assign tx_go = tx_st_q == TX_IDLE && te && !tx_empty_q
        && !(sync && err_any);
    assign tx_done = tx_st_q == TX_RUN && (sync
        ? (sck_rise && tx_bit_q == 4'h7)
        : (tick && tx_ph_q == PH_LAST && tx_bit_q == tx_last));
    always_comb
    begin
        if (sync)
        begin
            frame = {{3{txh_q[7]}}, txh_q};
        end
        else if (par_en)
        begin
            frame = {1'b1, ^txh_q, txh_q, 1'b0};
        end
        else
        begin
            frame = {2'h3, txh_q, 1'b0};
        end
    end

    // ----------------------------------------
    // control and port registers
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= CTRL_RST;
            dir_q <= PORT_RST[PB_DIR];
            lvl_q <= PORT_RST[PB_LVL];
        end
        else if (ce_i)
        begin
            if (wr_i && addr_i == OFF_CTRL)
            begin
                ctrl_q <= wdata_i;
            end
            if (wr_i && addr_i == OFF_PORT)
            begin
                dir_q <= wdata_i[PB_DIR];
                lvl_q <= wdata_i[PB_LVL];
            end
        end
    end

    // holding register takes every write, even over unsent data
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            txh_q <= 8'hff;
        end
        else if (ce_i && wr_txh)
        begin
            txh_q <= wdata_i;
        end
    end

    // ----------------------------------------
    // status flags, hardware set wins over clear
    // ----------------------------------------
    logic clr_txe, clr_rxf;
    assign clr_txe = wr_txh | (wr_stat & ~wdata_i[SB_TXE]);
    assign clr_rxf = rd_rxh | (wr_stat & ~wdata_i[SB_RXF]);

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_empty_q <= STAT_RST[SB_TXE];
            rx_full_q <= STAT_RST[SB_RXF];
            ovr_q <= STAT_RST[SB_OVR];
            fer_q <= STAT_RST[SB_FER];
            per_q <= STAT_RST[SB_PER];
            tx_end_q <= STAT_RST[SB_TX_END_FLAG];
        end
        else if (ce_i)
        begin
            tx_empty_q <= tx_go | ~te | (tx_empty_q & ~clr_txe);
            // an overrun holds receive-full up even against a same-cycle read
            rx_full_q <= full_set | ovr_set | (rx_full_q & ~clr_rxf);
            ovr_q <= ovr_set | (ovr_q & ~(wr_stat & ~wdata_i[SB_OVR]));
            fer_q <= fer_set | (fer_q & ~(wr_stat & ~wdata_i[SB_FER]));
            per_q <= per_set | (per_q & ~(wr_stat & ~wdata_i[SB_PER]));
            // transmit end when sending finishes with no new data written in time, and held set while transmit is disabled
            tx_end_q <= (tx_done & tx_empty_q) | ~te
                | (tx_end_q & ~tx_go);
        end
    end

    // receive holding register is loaded on every transfer, framing and parity errors included
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rxh_q <= 8'h00;
        end
        else if (ce_i && xfer)
        begin
            rxh_q <= rx_word;
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_q <= 16'h0000;
        end
        else if (ce_i)
        begin
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // disabling drops any frame in flight
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_st_q <= TX_IDLE;
            tx_fr_q <= 11'h7ff;
            tx_ph_q <= 4'h0;
            tx_bit_q <= 4'h0;
        end
        else if (ce_i)
        begin
            if (!te)
            begin
                tx_st_q <= TX_IDLE;
                tx_fr_q <= 11'h7ff;
                tx_ph_q <= 4'h0;
                tx_bit_q <= 4'h0;
            end
            else if (tx_go)
            begin
                tx_st_q <= TX_RUN;
                tx_fr_q <= frame;
                tx_ph_q <= 4'h0;
                tx_bit_q <= 4'h0;
            end
            else if (tx_done)
            begin
                tx_st_q <= TX_IDLE;
            end
            else if (tx_st_q == TX_RUN && sync)
            begin
                // data changes on falling clock, sampled on rising
                if (sck_rise)
                begin
                    tx_bit_q <= tx_bit_q + 4'h1;
                end
                if (sck_fall && tx_bit_q != 4'h0)
                begin
                    tx_fr_q <= {tx_fr_q[10], tx_fr_q[10:1]};
                end
            end
            else if (tx_st_q == TX_RUN && tick)
            begin
                tx_ph_q <= tx_ph_q + 4'h1;
                if (tx_ph_q == PH_LAST)
                begin
                    tx_fr_q <= {tx_fr_q[10], tx_fr_q[10:1]};
                    tx_bit_q <= tx_bit_q + 4'h1;
                end
            end
        end
    end

    // pin shows the port level until transmit is enabled
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            txd_q <= 1'b1;
        end
        else if (ce_i)
        begin
            txd_q <= te ? tx_fr_q[0] : lvl_q;
        end
    end

    assign txd_o = txd_q;
    assign txd_oe_o = te | dir_q;

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdiv_q <= 16'h0000;
        end
        else if (ce_i)
        begin
            if (rx_start || rtick)
            begin
                rdiv_q <= 16'h0000;
            end
            else
            begin
                rdiv_q <= rdiv_q + 16'h0001;
            end
        end
    end

    // asynchronous frame: start, data, optional parity, stop
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_st_q <= RX_IDLE;
            rx_ph_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_pb_q <= 1'b0;
            brk_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!re || sync)
            begin
                rx_st_q <= RX_IDLE;
            end
            else if (rx_start)
            begin
                rx_st_q <= RX_RUN;
                rx_ph_q <= 4'h0;
                rx_bit_q <= 4'h0;
            end
            else if (rx_st_q == RX_RUN && rtick)
            begin
                rx_ph_q <= rx_ph_q + 4'h1;
                if (as_smp)
                begin
                    if (rx_bit_q == 4'h0 && rxd_f)
                    begin
                        rx_st_q <= RX_IDLE; // glitch, not a start
                    end
                    if (rx_bit_q == 4'h9 && par_en)
                    begin
                        rx_pb_q <= rxd_f;
                    end
                    if (as_fin)
                    begin
                        rx_st_q <= RX_IDLE;
                        brk_q <= ~rxd_f;
                    end
                end
                if (rx_ph_q == PH_LAST)
                begin
                    rx_bit_q <= rx_bit_q + 4'h1;
                end
            end
            if (rx_start && !rxd_p)
            begin
                brk_q <= 1'b0;
            end
        end
    end

    // shift register, fed by the async sampler or sync rising clock
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_sh_q <= 8'h00;
        end
        else if (ce_i)
        begin
            if (as_smp && rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8)
            begin
                rx_sh_q <= {rxd_f, rx_sh_q[7:1]};
            end
            else if (sync && re && sck_rise)
            begin
                rx_sh_q <= {rxd_f, rx_sh_q[7:1]};
            end
        end
    end

    // sync mode bit count and delayed transfer window
    logic [3:0] sy_cnt_q;
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sy_cnt_q <= 4'h0;
            pend_q <= 2'h0;
        end
        else if (ce_i)
        begin
            if (!sync)
            begin
                sy_cnt_q <= 4'h0;
                pend_q <= 2'h0;
            end
            else if (sy_abort)
            begin
                pend_q <= 2'h0;
                sy_cnt_q <= 4'h0;
            end
            else if (re && sck_rise)
            begin
                sy_cnt_q <= (sy_cnt_q == 4'h7) ? 4'h0 : sy_cnt_q + 4'h1;
                if (sy_cnt_q == 4'h7)
                begin
                    pend_q <= RX_XFER_CYC;
                end
            end
            else if (pend_q != 2'h0)
            begin
                pend_q <= pend_q - 2'h1;
            end
        end
    end

    // ----------------------------------------
    // interrupt requests and priority
    // ----------------------------------------
    logic req_err, req_rxf, req_txe, req_tx_end_flag;
    assign req_err = err_any & ctrl_q[CB_RIE];
    assign req_rxf = rx_full_q & ctrl_q[CB_RIE];
    assign req_txe = tx_empty_q & ctrl_q[CB_TIE];
    assign req_tx_end_flag = tx_end_q & ctrl_q[CB_TX_END_IRQ_ENABLE];

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_err_irq_q <= 1'b0;
            rx_full_irq_q <= 1'b0;
            tx_empty_irq_q <= 1'b0;
            tx_end_irq_q <= 1'b0;
            irq_code_q <= IRQ_NONE;
        end
        else if (ce_i)
        begin
            rx_err_irq_q <= req_err;
            rx_full_irq_q <= req_rxf;
            tx_empty_irq_q <= req_txe;
            tx_end_irq_q <= req_tx_end_flag;
            if (req_err)
            begin
                irq_code_q <= IRQ_ERR;
            end
            else if (req_rxf)
            begin
                irq_code_q <= IRQ_RXF;
            end
            else if (req_txe)
            begin
                irq_code_q <= IRQ_TXE;
            end
            else
            begin
                irq_code_q <= req_tx_end_flag ? IRQ_TX_END_FLAG : IRQ_NONE;
            end
        end
    end

    assign rx_error_irq_o = rx_err_irq_q;
    assign rx_full_irq_o = rx_full_irq_q;
    assign tx_empty_irq_o = tx_empty_irq_q;
    assign tx_end_irq_o = tx_end_irq_q;
    assign irq_code_o = irq_code_q;

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (ce_i)
        begin
            rdata_q <= 8'h00;
            if (rd_i)
            begin
                case (addr_i)
                    OFF_CTRL: rdata_q <= ctrl_q;
                    OFF_STAT: rdata_q <= {tx_empty_q, rx_full_q, ovr_q,
                        fer_q, per_q, tx_end_q, 2'h0};
                    OFF_TXH: rdata_q <= txh_q;
                    OFF_RXH: rdata_q <= rxh_q;
                    OFF_PORT: rdata_q <= {5'h00, rxd_f, dir_q, lvl_q};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign rdata_o = rdata_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i || !ce_i);

    AST_TXE_IRQ: assert property (req_txe |=> tx_empty_irq_o)
        else $error("tx empty request missing");
    AST_RXF_OFF: assert property (!req_rxf |=> !rx_full_irq_o)
        else $error("rx full request without cause");
    AST_ERR_IRQ: assert property (err_any && ctrl_q[CB_RIE] |=> rx_error_irq_o)
        else $error("rx error request missing");
    AST_TX_END_FLAG_GATE: assert property (!ctrl_q[CB_TX_END_IRQ_ENABLE] |=> !tx_end_irq_o)
        else $error("tx end request while disabled");
    AST_TXH_CLR: assert property (wr_txh && te && !tx_go |=> !tx_empty_q)
        else $error("holding write did not clear empty flag");
    AST_RXH_CLR: assert property (rd_rxh && !full_set |=> !rx_full_q)
        else $error("holding read did not clear full flag");
    AST_OVR: assert property (rx_fin && rx_full_q
        |=> ovr_q && rx_full_q && $stable(rxh_q))
        else $error("overrun handled wrongly");
    AST_GO_SET: assert property (tx_go |=> tx_empty_q && tx_st_q == TX_RUN)
        else $error("load did not set empty flag");
    AST_BLOCK: assert property (sync && err_any && tx_st_q == TX_IDLE
        |=> tx_st_q == TX_IDLE)
        else $error("transmit started over receive error");
    AST_TE_OFF: assert property (!te [*2] |=> txd_o == $past(lvl_q)
        && tx_st_q == TX_IDLE)
        else $error("pin not showing port level");
    AST_PRIO: assert property (req_err |=> irq_code_o == IRQ_ERR)
        else $error("priority code wrong");
    AST_ABORT: assert property (sy_abort && !clr_rxf |=> rx_full_q
        && $stable(rxh_q))
        else $error("late disable handled wrongly");

    COV_OVR: cover property (ovr_set);
    COV_TX_END_FLAG: cover property (tx_done ##1 tx_end_irq_o);
    COV_ABORT: cover property (sy_abort);
    COV_BRK: cover property (rx_start && brk_q);
endmodule : serial_channel
`default_nettype wire

// ===== inc/serial_pkg.sv
// Notes on behaviour
// - four separate request lines: receive error, receive full, transmit empty, transmit end.
// - requests are gated by the tx, rx and tx-end enable bits in control.
// - transmit-empty request follows the transmit-empty flag.
// - writing the transmit holding register clears the transmit-empty flag while transmit is enabled.
// - receive-full request follows the receive-full flag.
// - reading the receive holding register clears the receive-full flag.
// - receive-error request when overrun, parity or framing flag is set.
// - transmit-end request follows the transmit-end flag, set when sending completes with no new data waiting.
// - fixed priority: receive error, receive full, transmit empty, transmit end.
// - moving holding data into the shift register sets transmit-empty.
// - holding register accepts writes at any time; early writes overwrite data.
// - overrun sets its flag, keeps receive-full, discards the received word.
// - framing and parity errors set flags, keep receive-full low, store the word.
// - receiver keeps running during a break, so framing error sets again.
// - port register holds pin direction and level bits, both reset to one.
// - while transmit is disabled the pin shows the port level bit.
// - clearing transmit enable resets the transmitter at once.
// - synchronous mode: any receive error flag blocks the start of transmission.
// - asynchronous receiver uses sixteen ticks per bit, aligned to start edge.
// - each asynchronous bit is sampled on the eighth tick of the bit.
// - rx enable cleared late in the last bit: receive-full set, no copy.
// - asynchronous mode has no late-clear rule: clearing rx enable drops the frame, no flag set.
// - receive-error request only with the receive interrupt enable set.
// - transmit-end request only with its enable set.
package serial_pkg;
    // register map
    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_STAT = 3'h1;
    localparam logic [2:0] OFF_TXH = 3'h2;
    localparam logic [2:0] OFF_RXH = 3'h3;
    localparam logic [2:0] OFF_PORT = 3'h4;
    // control bits
    localparam int CB_TIE = 7;
    localparam int CB_RIE = 6;
    localparam int CB_TE = 5;
    localparam int CB_RE = 4;
    localparam int CB_TX_END_IRQ_ENABLE = 2;
    localparam int CB_SYNC = 1;
    localparam int CB_PAR = 0;
    // status bits
    localparam int SB_TXE = 7;
    localparam int SB_RXF = 6;
    localparam int SB_OVR = 5;
    localparam int SB_FER = 4;
    localparam int SB_PER = 3;
    localparam int SB_TX_END_FLAG = 2;
    // port bits
    localparam int PB_LVL = 0;
    localparam int PB_DIR = 1;
    localparam int PB_PIN = 2;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h84;
    localparam logic [1:0] PORT_RST = 2'h3;
    // timing in base ticks and cycles
    localparam logic [3:0] PH_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_PH = 4'h7;
    localparam logic [1:0] RX_XFER_CYC = 2'h3;
    // interrupt priority codes
    localparam logic [2:0] IRQ_NONE = 3'h0;
    localparam logic [2:0] IRQ_TX_END_FLAG = 3'h1;
    localparam logic [2:0] IRQ_TXE = 3'h2;
    localparam logic [2:0] IRQ_RXF = 3'h3;
    localparam logic [2:0] IRQ_ERR = 3'h4;
    typedef enum logic [0:0] {TX_IDLE, TX_RUN} tx_state_type;
    typedef enum logic [0:0] {RX_IDLE, RX_RUN} rx_state_type;
endpackage : serial_pkg
